// >>> inc/dsw_pkg.sv
package dsw_pkg;

    // ========================================================================
    // Clock and time bases
    // ========================================================================
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
    localparam int unsigned STBY_TICK_MS = 100;
    localparam int unsigned STBY_DIV = STBY_TICK_MS / TICK_MS;

    // ========================================================================
    // Register offsets (byte addresses)
    // ========================================================================
    localparam logic [7:0] REG_STBY = 8'h00;
    localparam logic [7:0] REG_COMMS = 8'h04;
    localparam logic [7:0] REG_TMO = 8'h08;
    localparam logic [7:0] REG_MOTOR = 8'h0c;
    localparam logic [7:0] REG_STS = 8'h10;
    localparam logic [7:0] REG_MSK = 8'h14;
    localparam logic [7:0] REG_STATE = 8'h18;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int unsigned F_WAKE_LSB = 16;
    localparam int unsigned F_RATE_LSB = 8;
    localparam int unsigned F_ACT_BIT = 12;
    localparam int unsigned F_CANSUP_BIT = 13;
    localparam int unsigned F_ATUNE_BIT = 16;
    localparam int unsigned ST_STBY = 0;
    localparam int unsigned ST_TRIP = 1;
    localparam int unsigned ST_COAST = 2;
    localparam int unsigned ST_CAN = 3;
    localparam int unsigned EV_STBY = 0;
    localparam int unsigned EV_WAKE = 1;
    localparam int unsigned EV_TRIP = 2;
    localparam int unsigned EV_COAST = 3;
    localparam int unsigned EV_N = 4;

    // ========================================================================
    // Reset values and limits
    // ========================================================================
    localparam logic [7:0] STBY_DLY_RST = 8'h00;
    localparam logic [7:0] STBY_DLY_MAX = 8'hfa;
    localparam logic [9:0] WAKE_RST = 10'h032;
    localparam logic [9:0] WAKE_MAX = 10'h3e8;
    localparam logic [5:0] ADDR_RST = 6'h01;
    localparam logic [5:0] ADDR_MIN = 6'h01;
    localparam logic [5:0] ADDR_MAX = 6'h3f;
    localparam logic [3:0] RATE_RST = 4'h4;
    localparam logic [3:0] RATE_CAN0 = 4'h5;
    localparam logic [3:0] RATE_MAX = 4'h8;
    localparam logic [15:0] TMO_RST = 16'h012c;
    localparam logic [15:0] TMO_MAX = 16'hea60;
    localparam logic [10:0] CUR_RST = 11'h5dc;
    localparam logic [10:0] CUR_MAX = 11'h6d6;

    // ========================================================================
    // Bit rates in bit/s and the matching bit period in clock cycles
    // ========================================================================
    localparam int unsigned BAUD_HZ [9] = '{9600, 19200, 38400, 57600, 115200,
                                           125000, 250000, 500000, 1000000};

    // Rounds to the nearest whole cycle; the worst error is below 0.07 %.
    function automatic logic [12:0] baud_div(input logic [3:0] code);
        int unsigned r;
        r = BAUD_HZ[(code > RATE_MAX) ? RATE_MAX : code];
        return 13'((CLK_HZ + r / 2) / r);
    endfunction : baud_div

    typedef enum logic [1:0] {
        DSW_RUN = 2'b01,
        DSW_STBY = 2'b10
    } dsw_mode_t;

endpackage : dsw_pkg

// >>> inc/dsw_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries one elapsed-time counter between its user and the counter itself.
interface dsw_tmr_if;
    logic run;
    logic clr;
    logic tick;
    logic [15:0] cnt;

    modport ctl (output run, output clr, output tick, input cnt);
    modport tmr (input run, input clr, input tick, output cnt);
endinterface : dsw_tmr_if

`default_nettype wire

// >>> src/dsw_div.sv
`timescale 1ns/10ps
`default_nettype none

module dsw_div #(
    parameter int unsigned DIV = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    output logic tick_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } dsw_div_st_t;

    dsw_div_st_t st_ff;
    dsw_div_st_t nxt_st;

    // ========================================================================
    // Free running divider, one pulse every DIV enabled cycles
    // ========================================================================
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (en_i)
        begin
            if (st_ff.cnt >= DIV - 1)
            begin
                nxt_st.cnt = '0;
                nxt_st.tick = 1'b1;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 32'h1;
            end
        end
    end

    // Register the whole state.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick_o = st_ff.tick;

    a_div_single: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |=> !tick_o)
        else $error("divider pulse lasted more than one cycle");

endmodule : dsw_div

`default_nettype wire

// >>> src/dsw_tmr.sv
`timescale 1ns/10ps
`default_nettype none

module dsw_tmr (
    input wire logic clk_i,
    input wire logic rst_i,
    dsw_tmr_if.tmr bus
);
    typedef struct packed {
        logic [15:0] cnt;
    } dsw_tmr_st_t;

    dsw_tmr_st_t st_ff;
    dsw_tmr_st_t nxt_st;

    // ========================================================================
    // Tick counter; saturates so that a stuck run never wraps to a small value
    // ========================================================================
    always_comb
    begin
        nxt_st = st_ff;
        if (bus.clr)
            nxt_st.cnt = '0;
        else if (bus.run && bus.tick && (st_ff.cnt != 16'hffff))
            nxt_st.cnt = st_ff.cnt + 16'h1;
    end

    // Register the whole state.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign bus.cnt = st_ff.cnt;

    a_tmr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.clr |=> (bus.cnt == 16'h0))
        else $error("timer not zero after clear");

endmodule : dsw_tmr

`default_nettype wire

// >>> src/dsw_top.sv
// Summary of operation
// - Nonzero standby delay: enter standby after that long continuously at minimum speed.
// - In standby, raise the standby indication and keep motor output disabled.
// - PI mode: leave standby once PI error reaches the wake level.
// - Node address holds 1 to 63, reset value 1.
// - Modbus rates 9.6, 19.2, 38.4, 57.6, 115.2 kbps; 115.2 default.
// - Same setting picks CAN 125, 250, 500, 1000 kbps and CAN mode.
// - While enabled, act when time without a valid telegram exceeds timeout.
// - Timeout covers serial bus only; CAN loss has its own enable.
// - Timeout of zero disables the communication watchdog completely.
// - Action selector: trip, or coast stop without tripping.
// - Current limit setting up to 175.0 %, default 150.0 %.
// - Writing one to autotune starts motor measurement at once.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module dsw_top
    import dsw_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic drive_enable_i,
    input wire logic min_speed_i,
    input wire logic pi_mode_i,
    input wire logic [9:0] pi_err_i,
    input wire logic telegram_valid_i,
    input wire logic can_loss_i,
    input wire logic autotune_done_i,
    output logic motor_en_o,
    output logic standby_o,
    output logic trip_o,
    output logic coast_o,
    output logic [5:0] node_addr_o,
    output logic [3:0] rate_sel_o,
    output logic can_mode_o,
    output logic [12:0] baud_div_o,
    output logic [10:0] cur_lim_o,
    output logic autotune_o,
    output logic irq_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] stby_dly;
        logic [9:0] wake_lvl;
        logic [5:0] addr;
        logic [3:0] rate;
        logic act_trip;
        logic can_sup;
        logic [15:0] tmo;
        logic [10:0] cur_lim;
        logic atune;
        logic [EV_N-1:0] sts;
        logic [EV_N-1:0] msk;
        dsw_mode_t mode;
        logic trip;
        logic coast;
        logic motor_en;
        logic [12:0] bdiv;
        logic irq;
        logic stby;
        logic canm;
    } dsw_top_st_t;

    dsw_top_st_t st_ff;
    dsw_top_st_t nxt_st;
    logic ms_tick;
    logic stby_tick;
    logic wr;
    logic rd;
    logic [31:0] bmask;
    logic [31:0] wword;
    logic [31:0] cur_word;
    logic can_mode;
    logic stby_run;
    logic stby_enter;
    logic wake;
    logic wd_fire;
    logic can_fire;
    logic loss;
    logic [EV_N-1:0] ev;

    dsw_tmr_if stby_t ();
    dsw_tmr_if wd_t ();

    // ========================================================================
    // Time bases: 1 ms for the watchdog, 100 ms for the standby delay
    // ========================================================================
    dsw_div #(.DIV(MS_CYC)) u_ms_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(1'b1),
        .tick_o(ms_tick)
    );

    dsw_div #(.DIV(STBY_DIV)) u_stby_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(ms_tick),
        .tick_o(stby_tick)
    );

    dsw_tmr u_stby_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(stby_t.tmr)
    );

    dsw_tmr u_wd_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(wd_t.tmr)
    );

    // ========================================================================
    // Supervisory decisions
    // ========================================================================
    // The free running dividers mean the first tick of a run may come early,
    // so each delay is met to within one tick; a cheaper trade than restarting
    // the dividers on every run.
    always_comb
    begin
        can_mode = st_ff.canm;
        stby_run = drive_enable_i && min_speed_i && (st_ff.mode == DSW_RUN)
            && (st_ff.stby_dly != STBY_DLY_RST);
        stby_enter = stby_run && (stby_t.cnt >= {8'h00, st_ff.stby_dly});
        wake = (st_ff.mode == DSW_STBY) && (!drive_enable_i
            || (pi_mode_i ? (pi_err_i >= st_ff.wake_lvl) : !min_speed_i));
        wd_fire = drive_enable_i && !can_mode && (st_ff.tmo != 16'h0)
            && (wd_t.cnt > st_ff.tmo) && !st_ff.trip && !st_ff.coast;
        can_fire = drive_enable_i && can_mode && st_ff.can_sup && can_loss_i
            && !st_ff.trip && !st_ff.coast;
        loss = wd_fire || can_fire;
        ev = '0;
        ev[EV_STBY] = stby_enter;
        ev[EV_WAKE] = wake;
        ev[EV_TRIP] = loss && st_ff.act_trip;
        ev[EV_COAST] = loss && !st_ff.act_trip;
    end

    // Timer controls; the loss timer restarts on each telegram and rests while disabled.
    assign stby_t.run = stby_run;
    assign stby_t.clr = !stby_run;
    assign stby_t.tick = stby_tick;
    assign wd_t.run = drive_enable_i && !can_mode && (st_ff.tmo != 16'h0);
    assign wd_t.clr = telegram_valid_i || !drive_enable_i;
    assign wd_t.tick = ms_tick;

    // ========================================================================
    // Wishbone decode and byte lane merge
    // ========================================================================
    always_comb
    begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack;
        bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        cur_word = '0;
        case (wb_adr_i)
            REG_STBY:
            begin
                cur_word[7:0] = st_ff.stby_dly;
                cur_word[F_WAKE_LSB +: 10] = st_ff.wake_lvl;
            end
            REG_COMMS:
            begin
                cur_word[5:0] = st_ff.addr;
                cur_word[F_RATE_LSB +: 4] = st_ff.rate;
                cur_word[F_ACT_BIT] = st_ff.act_trip;
                cur_word[F_CANSUP_BIT] = st_ff.can_sup;
            end
            REG_TMO: cur_word[15:0] = st_ff.tmo;
            REG_MOTOR:
            begin
                cur_word[10:0] = st_ff.cur_lim;
                cur_word[F_ATUNE_BIT] = st_ff.atune;
            end
            REG_STS: cur_word[EV_N-1:0] = st_ff.sts;
            REG_MSK: cur_word[EV_N-1:0] = st_ff.msk;
            REG_STATE:
            begin
                cur_word[ST_STBY] = (st_ff.mode == DSW_STBY);
                cur_word[ST_TRIP] = st_ff.trip;
                cur_word[ST_COAST] = st_ff.coast;
                cur_word[ST_CAN] = can_mode;
            end
            default: cur_word = '0;
        endcase
        wword = (cur_word & ~bmask) | (wb_dat_i & bmask);
    end

    // ========================================================================
    // Next state
    // ========================================================================
    // Out of range values are dropped whole, so a setting never holds a value
    // the drive cannot use.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
        nxt_st.rdat = rd ? cur_word : '0;
        if (wr)
        begin
            case (wb_adr_i)
                REG_STBY:
                begin
                    if (wword[7:0] <= STBY_DLY_MAX)
                        nxt_st.stby_dly = wword[7:0];
                    if (wword[F_WAKE_LSB +: 10] <= WAKE_MAX)
                        nxt_st.wake_lvl = wword[F_WAKE_LSB +: 10];
                end
                REG_COMMS:
                begin
                    if (wword[5:0] >= ADDR_MIN)
                        nxt_st.addr = wword[5:0];
                    if (wword[F_RATE_LSB +: 4] <= RATE_MAX)
                        nxt_st.rate = wword[F_RATE_LSB +: 4];
                    nxt_st.act_trip = wword[F_ACT_BIT];
                    nxt_st.can_sup = wword[F_CANSUP_BIT];
                end
                REG_TMO:
                begin
                    if (wword[15:0] <= TMO_MAX)
                        nxt_st.tmo = wword[15:0];
                end
                REG_MOTOR:
                begin
                    if (wword[10:0] <= CUR_MAX)
                        nxt_st.cur_lim = wword[10:0];
                end
                REG_MSK: nxt_st.msk = wword[EV_N-1:0];
                default: nxt_st.msk = st_ff.msk;
            endcase
        end
        // Autotune starts on a written one and ends when the measurement reports done.
        if (wr && (wb_adr_i == REG_MOTOR) && wb_dat_i[F_ATUNE_BIT] && bmask[F_ATUNE_BIT])
            nxt_st.atune = 1'b1;
        else if (autotune_done_i)
            nxt_st.atune = 1'b0;
        // Sticky events; only selected lanes clear, and a new event in that cycle survives.
        if (wr && (wb_adr_i == REG_STS))
            nxt_st.sts = (st_ff.sts & ~(wb_dat_i[EV_N-1:0] & bmask[EV_N-1:0])) | ev;
        else
            nxt_st.sts = st_ff.sts | ev;
        case (st_ff.mode)
            DSW_RUN: if (stby_enter) nxt_st.mode = DSW_STBY;
            DSW_STBY: if (wake) nxt_st.mode = DSW_RUN;
            default: nxt_st.mode = DSW_RUN;
        endcase
        // A trip is held until software clears it; a coast stop ends when disabled.
        if (ev[EV_TRIP])
            nxt_st.trip = 1'b1;
        else if (wr && (wb_adr_i == REG_STATE) && wb_dat_i[ST_TRIP] && bmask[ST_TRIP])
            nxt_st.trip = 1'b0;
        if (ev[EV_COAST])
            nxt_st.coast = 1'b1;
        else if (!drive_enable_i)
            nxt_st.coast = 1'b0;
        nxt_st.motor_en = drive_enable_i && (nxt_st.mode == DSW_RUN)
            && !nxt_st.trip && !nxt_st.coast;
        nxt_st.bdiv = baud_div(nxt_st.rate);
        nxt_st.canm = (nxt_st.rate >= RATE_CAN0);
        nxt_st.stby = (nxt_st.mode == DSW_STBY);
        nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
    end

    // Register the whole state.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
            st_ff.stby_dly <= STBY_DLY_RST;
            st_ff.wake_lvl <= WAKE_RST;
            st_ff.addr <= ADDR_RST;
            st_ff.rate <= RATE_RST;
            st_ff.tmo <= TMO_RST;
            st_ff.cur_lim <= CUR_RST;
            st_ff.mode <= DSW_RUN;
            st_ff.bdiv <= baud_div(RATE_RST);
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ========================================================================
    // Outputs, all straight from the state register
    // ========================================================================
    assign wb_dat_o = st_ff.rdat;
    assign wb_ack_o = st_ff.ack;
    assign motor_en_o = st_ff.motor_en;
    assign standby_o = st_ff.stby;
    assign trip_o = st_ff.trip;
    assign coast_o = st_ff.coast;
    assign node_addr_o = st_ff.addr;
    assign rate_sel_o = st_ff.rate;
    assign can_mode_o = st_ff.canm;
    assign baud_div_o = st_ff.bdiv;
    assign cur_lim_o = st_ff.cur_lim;
    assign autotune_o = st_ff.atune;
    assign irq_o = st_ff.irq;

    // ========================================================================
    // Assertions
    // ========================================================================
    sequence s_wake_cond;
        standby_o && drive_enable_i && pi_mode_i && (pi_err_i >= st_ff.wake_lvl);
    endsequence

    a_stby_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(standby_o) |-> ($past(st_ff.stby_dly) != 8'h00)
            && ($past(stby_t.cnt) >= {8'h00, $past(st_ff.stby_dly)}))
        else $error("standby entered before its delay");
    a_stby_motor_off: assert property (@(posedge clk_i) disable iff (rst_i)
        standby_o |-> !motor_en_o)
        else $error("motor enabled in standby");
    a_pi_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wake_cond |=> !standby_o)
        else $error("no wake on PI error");
    a_addr_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (node_addr_o >= ADDR_MIN) && (node_addr_o <= ADDR_MAX))
        else $error("node address out of range");
    a_rate_div: assert property (@(posedge clk_i) disable iff (rst_i)
        (rate_sel_o <= RATE_MAX) && (baud_div_o == baud_div(rate_sel_o)))
        else $error("bit period does not match rate");
    a_can_select: assert property (@(posedge clk_i) disable iff (rst_i)
        can_mode_o |-> (baud_div_o <= baud_div(RATE_CAN0)))
        else $error("CAN mode with serial bit period");
    a_wd_exceed: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(trip_o) |-> $past(can_fire) || ($past(wd_t.cnt) > $past(st_ff.tmo)))
        else $error("watchdog fired early");
    a_wd_can_off: assert property (@(posedge clk_i) disable iff (rst_i)
        can_mode_o |=> $stable(wd_t.cnt) || (wd_t.cnt == 16'h0))
        else $error("serial watchdog fired in CAN mode");
    a_wd_zero_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.tmo == 16'h0) |=> $stable(wd_t.cnt) || (wd_t.cnt == 16'h0))
        else $error("disabled watchdog fired");
    a_loss_action: assert property (@(posedge clk_i) disable iff (rst_i)
        loss |=> ($past(st_ff.act_trip) ? trip_o : (coast_o && !trip_o)) && !motor_en_o)
        else $error("wrong loss action");
    a_cur_range: assert property (@(posedge clk_i) disable iff (rst_i)
        cur_lim_o <= CUR_MAX)
        else $error("current limit out of range");
    a_atune_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && (wb_adr_i == REG_MOTOR) && wb_sel_i[2] && wb_dat_i[F_ATUNE_BIT]) |=> autotune_o)
        else $error("autotune did not start");
    a_wd_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (telegram_valid_i || !drive_enable_i) |=> (wd_t.cnt == 16'h0))
        else $error("loss timer not restarted");

endmodule : dsw_top

`default_nettype wire

// >>> verif/dsw_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Fieldbus master model
// ============================================================================
module dsw_master_model (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic [15:0] gap_i,
    output logic telegram_valid_o
);
    int cnt;
    bit pulse;

    // One valid command telegram every gap_i + 1 cycles while sending.
    // A two-state pulse keeps the line low from time zero, before any edge.
    always_ff @(posedge clk_i)
    begin
        cnt <= (en_i && cnt < int'(gap_i)) ? cnt + 1 : 0;
        pulse <= en_i && cnt == int'(gap_i);
    end
    assign telegram_valid_o = pulse;
endmodule : dsw_master_model

`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Testbench top
// ============================================================================
module tb_top
    import dsw_pkg::*;
;
    localparam int MS = 40;
    logic clk_i, rst_i, cyc, stb, we, en, mins, pim, tv, canl, atd, tx;
    logic [7:0] adr;
    logic [31:0] wdat, q;
    logic [9:0] perr;
    logic [15:0] gap;
    logic [3:0] sel;
    wire [31:0] rdat;
    wire ack, men, sby, trp, cst, canm, atn, irq;
    wire [5:0] naddr;
    wire [3:0] rsel;
    wire [12:0] bdiv;
    wire [10:0] clim;
    int fail_count, checks_done, bps[9], a;

    dsw_top #(.MS_CYC(MS)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .drive_enable_i(en), .min_speed_i(mins), .pi_mode_i(pim),
        .pi_err_i(perr), .telegram_valid_i(tv), .can_loss_i(canl), .autotune_done_i(atd),
        .motor_en_o(men), .standby_o(sby), .trip_o(trp), .coast_o(cst), .node_addr_o(naddr),
        .rate_sel_o(rsel), .can_mode_o(canm), .baud_div_o(bdiv), .cur_lim_o(clim),
        .autotune_o(atn), .irq_o(irq));
    dsw_master_model u_master (.clk_i(clk_i), .en_i(tx), .gap_i(gap), .telegram_valid_o(tv));

    task final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One classic cycle; the request stands until ack is sampled high.
    task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50)
        begin
            fail_count++;
            final_report();
        end
        @(posedge clk_i);
    endtask : wb

    initial
    begin
        clk_i = 0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial
    begin
        {rst_i, cyc, stb, we, en, mins, pim, canl, atd, tx} = 10'h200;
        {adr, wdat, perr, gap} = '0;
        sel = 4'hf;
        bps = '{9600, 19200, 38400, 57600, 115200, 125000, 250000, 500000, 1000000};
        void'($urandom(32'hd1620ec7));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, REG_COMMS, 0); chk(q, 32'h401);
        wb(0, REG_TMO, 0); chk(q, 32'd300);
        wb(0, REG_MOTOR, 0); chk(q, 32'd1500);
        wb(0, REG_STBY, 0); chk(q, 32'h320000);
        $display("reset values done");
        // Every rate code, with a random legal address; address zero must be refused.
        for (int c = 0; c < 9; c++)
        begin
            a = 1 + $urandom % 63;
            wb(1, REG_COMMS, 32'(a) | (c << 8));
            chk(bdiv, (40000000 + bps[c] / 2) / bps[c]);
            chk({canm, rsel, naddr}, {c >= 5, 4'(c), 6'(a)});
            wb(1, REG_COMMS, c << 8); chk(naddr, a);
        end
        $display("rates done");
        wb(1, REG_COMMS, 32'h1401); wb(1, REG_TMO, 3); wb(1, REG_MSK, 32'hf);
        gap <= 16'(40 + $urandom % 60); tx <= 1'b1; en <= 1'b1;
        repeat (600) @(posedge clk_i);
        chk({trp, men}, 2'b01);
        // Stop right after a telegram, so that the silent time is known to the cycle.
        for (int i = 0; i < 200 && !tv; i++) @(posedge clk_i);
        chk(tv, 1);
        if (!tv)
            final_report();
        tx <= 1'b0;
        repeat (3 * MS) @(posedge clk_i);
        chk(trp, 0);
        repeat (2 * MS + 4) @(posedge clk_i);
        chk({trp, men, irq}, 3'b101);
        wb(0, REG_STS, 0); chk(q, 32'h4);
        // A clear through an unselected byte lane must leave the status alone.
        sel <= 4'he; wb(1, REG_STS, 32'h4); sel <= 4'hf;
        chk(irq, 1);
        en <= 1'b0;
        wb(1, REG_STS, 32'h4); wb(1, REG_STATE, 32'h2); chk({trp, irq}, 0);
        wb(1, REG_COMMS, 32'h401); en <= 1'b1;
        repeat (5 * MS + 4) @(posedge clk_i);
        chk({cst, trp, men}, 3'b100);
        en <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(cst, 0);
        wb(1, REG_STS, 32'hf); wb(1, REG_TMO, 0); en <= 1'b1;
        repeat (400) @(posedge clk_i);
        chk({cst, trp}, 0);
        wb(1, REG_TMO, 3); wb(1, REG_COMMS, 32'h2501);
        repeat (400) @(posedge clk_i);
        chk(cst, 0);
        canl <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(cst, 1);
        {en, canl} <= 2'b00;
        $display("watchdog done");
        wb(1, REG_COMMS, 32'h401); wb(1, REG_TMO, 0); wb(1, REG_STS, 32'hf);
        wb(1, REG_STBY, 32'h320001); {en, mins} <= 2'b11;
        repeat (100 * MS + 4) @(posedge clk_i);
        chk({sby, men, irq}, 3'b101);
        {pim, perr} <= {1'b1, 10'd49};
        repeat (5) @(posedge clk_i);
        chk(sby, 1);
        perr <= 10'd50;
        repeat (3) @(posedge clk_i);
        chk(sby, 0);
        en <= 1'b0;
        wb(1, REG_MOTOR, 32'h6d7); chk(clim, 32'd1500);
        wb(1, REG_MOTOR, 32'h105dc);
        chk({atn, clim}, {1'b1, 11'd1500});
        atd <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(atn, 0);
        $display("standby and autotune done");
        final_report();
    end
endmodule : tb_top

`default_nettype wire
